// File: hw/sgad_pkg.sv
// package for the serial gate and azimuth downloader
// assumes one 25 MHz clock domain and a byte-wide character link
package sgad_pkg;

    // ==========================================================
    // character codes and counts
    localparam logic [7:0] GATE_SELECT_CHAR = 8'h20;
    localparam logic [7:0] ACK_CHAR         = 8'h06;
    localparam logic [3:0] GATE_BYTES       = 4'hC;
    localparam logic [3:0] AZ_CHARS         = 4'h4;
    localparam logic [3:0] ASCII_DIGIT_HI   = 4'h3;
    localparam logic [1:0] SLEW_TO_HOST_AZ  = 2'h2;
    localparam logic [1:0] SLEW_IDLE        = 2'h0;
    localparam int         FIFO_DEPTH       = 4;
    localparam int         FIFO_WIDTH       = 8;

    // byte positions within a gate download (1-based)
    localparam logic [3:0] POS_ADDR_LO = 4'h2;
    localparam logic [3:0] POS_DATA_LO = 4'h5;
    localparam logic [3:0] POS_DATA_HI = 4'hA;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        SGAD_IDLE,
        SGAD_GATE,
        SGAD_AZ,
        SGAD_ACK
    } sgad_state_t;

    typedef struct packed {
        logic       is_cmd;
        logic [7:0] addr_hi;
        logic [7:0] addr_lo;
        logic [7:0] data;
    } sgad_chip_wr_t;

    typedef struct packed {
        sgad_state_t   state;
        logic [3:0]    count;
        logic [7:0]    addr_hi;
        logic [7:0]    addr_lo;
        logic [15:0]   az_buf;
        logic [15:0]   az_store;
        logic [1:0]    slew_flag;
        logic          wr_valid;
        sgad_chip_wr_t wr;
        logic          ack_valid;
    } sgad_regs_t;

    typedef struct packed {
        logic [1:0] rd_ptr;
        logic [1:0] wr_ptr;
        logic [2:0] level;
        logic [3:0][7:0] mem;
    } sgad_fifo_t;

endpackage

// File: hw/sgad_top.sv
// serial gate and azimuth downloader, with its input fifo
// assumes host characters arrive as valid/ready bytes on clk_in
`timescale 1ns/1ps

module sgad_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    // fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);

    // fifo state, one word
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rd;
        logic [AW-1:0]               wr;
        logic [AW:0]                 level;
    } sgad_fifo_state_t;

    sgad_fifo_state_t f_reg;
    sgad_fifo_state_t f_next;
    logic             push;
    logic             pop;

    assign in_ready_out  = (f_reg.level != (AW+1)'(DEPTH));
    assign out_valid_out = (f_reg.level != '0);
    assign out_data_out  = f_reg.mem[f_reg.rd];
    assign push = in_valid_in && in_ready_out;
    assign pop  = out_valid_out && out_ready_in;

    always_comb begin
        f_next = f_reg;
        if (push) begin
            f_next.mem[f_reg.wr] = in_data_in;
            f_next.wr            = f_reg.wr + AW'(1);
        end
        if (pop)
            f_next.rd = f_reg.rd + AW'(1);
        if (push && !pop)
            f_next.level = f_reg.level + (AW+1)'(1);
        else if (pop && !push)
            f_next.level = f_reg.level - (AW+1)'(1);
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            f_reg <= '0;
        end else begin
            f_reg <= f_next;
        end
    end

    // ==========================================================
    // checks
    // level within depth
    fifo_bound_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        f_reg.level <= (AW+1)'(DEPTH))
        else $error("fifo level above depth");

    fifo_pass_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        f_reg.level == '0 && push
        |=> out_valid_out && out_data_out == $past(in_data_in))
        else $error("fifo lost its first word");
endmodule

module sgad_top (
    // clock and reset
    input  wire logic                   clk_in,
    input  wire logic                   rst_b_in,
    // characters from host
    input  wire logic                   rx_valid_in,
    output logic                        rx_ready_out,
    input  wire logic [7:0]             rx_data_in,
    // acknowledge character to host
    output logic                        tx_valid_out,
    input  wire logic                   tx_ready_in,
    output logic [7:0]                  tx_data_out,
    // writes to the gate counter chip
    output logic                        chip_wr_valid_out,
    input  wire logic                   chip_wr_ready_in,
    output sgad_pkg::sgad_chip_wr_t     chip_wr_out,
    // antenna slew task interface
    output logic [15:0]                 host_azimuth_store_out,
    output logic [1:0]                  slew_request_flag_out,
    input  wire logic                   slew_flag_clear_in,
    // status
    output logic                        busy_out
);
    sgad_pkg::sgad_regs_t s_reg;
    sgad_pkg::sgad_regs_t s_next;
    logic                 f_valid;
    logic                 f_ready;
    logic [7:0]           f_data;
    logic                 take;

    // ==========================================================
    // input buffer
    sgad_fifo #(
        .WIDTH (sgad_pkg::FIFO_WIDTH),
        .DEPTH (sgad_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .rst_b_in      (rst_b_in),
        .in_valid_in   (rx_valid_in),
        .in_ready_out  (rx_ready_out),
        .in_data_in    (rx_data_in),
        .out_valid_out (f_valid),
        .out_ready_in  (f_ready),
        .out_data_out  (f_data)
    );

    // stall while a chip write or the ack is pending
    assign f_ready = (s_reg.state != sgad_pkg::SGAD_ACK)
                     && !(s_reg.wr_valid && !chip_wr_ready_in);
    assign take    = f_valid && f_ready;

    // ==========================================================
    // interpreter
    always_comb begin
        s_next = s_reg;
        if (s_reg.wr_valid && chip_wr_ready_in)
            s_next.wr_valid = 1'b0;
        if (slew_flag_clear_in)
            s_next.slew_flag = sgad_pkg::SLEW_IDLE;
        case (s_reg.state)
            sgad_pkg::SGAD_IDLE: begin
                if (take) begin
                    s_next.count = 4'h1;
                    if (f_data == sgad_pkg::GATE_SELECT_CHAR) begin
                        s_next.addr_hi = f_data;
                        s_next.state   = sgad_pkg::SGAD_GATE;
                    end else begin
                        s_next.count = 4'h0;
                        s_next.state = sgad_pkg::SGAD_AZ;
                    end
                end
            end
            sgad_pkg::SGAD_GATE: begin
                if (take) begin
                    s_next.count = s_reg.count + 4'h1;
                    if (s_next.count == sgad_pkg::POS_ADDR_LO) begin
                        s_next.addr_lo = f_data;
                    end else begin
                        s_next.wr_valid   = 1'b1;
                        s_next.wr.addr_hi = s_reg.addr_hi;
                        s_next.wr.data    = f_data;
                        if (s_next.count >= sgad_pkg::POS_DATA_LO &&
                            s_next.count <= sgad_pkg::POS_DATA_HI) begin
                            s_next.wr.is_cmd  = 1'b0;
                            s_next.wr.addr_lo = s_reg.addr_lo - 8'h01;
                        end else begin
                            s_next.wr.is_cmd  = 1'b1;
                            s_next.wr.addr_lo = s_reg.addr_lo;
                        end
                    end
                    if (s_next.count == sgad_pkg::GATE_BYTES) begin
                        s_next.state     = sgad_pkg::SGAD_ACK;
                        s_next.ack_valid = 1'b1;
                    end
                end
            end
            sgad_pkg::SGAD_AZ: begin
                if (take) begin
                    s_next.az_buf = {s_reg.az_buf[11:0], f_data[3:0]};
                    s_next.count  = s_reg.count + 4'h1;
                    if (s_next.count == sgad_pkg::AZ_CHARS) begin
                        s_next.az_store  = s_next.az_buf;
                        s_next.slew_flag = sgad_pkg::SLEW_TO_HOST_AZ;
                        s_next.state     = sgad_pkg::SGAD_ACK;
                        s_next.ack_valid = 1'b1;
                    end
                end
            end
            sgad_pkg::SGAD_ACK: begin
                if (tx_ready_in && !s_reg.wr_valid) begin
                    s_next.ack_valid = 1'b0;
                    s_next.state     = sgad_pkg::SGAD_IDLE;
                end else if (!s_reg.wr_valid) begin
                    s_next.ack_valid = 1'b1;
                end
            end
            default: s_next.state = sgad_pkg::SGAD_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ack waits until the last chip write is taken
    assign tx_valid_out           = s_reg.ack_valid && !s_reg.wr_valid;
    assign tx_data_out            = sgad_pkg::ACK_CHAR;
    assign chip_wr_valid_out      = s_reg.wr_valid;
    assign chip_wr_out            = s_reg.wr;
    assign host_azimuth_store_out = s_reg.az_store;
    assign slew_request_flag_out  = s_reg.slew_flag;
    assign busy_out = (s_reg.state != sgad_pkg::SGAD_IDLE);

    // ==========================================================
    // checks
    // gate selector decode
    sel_gate_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        s_reg.state == sgad_pkg::SGAD_IDLE && take
        && f_data == sgad_pkg::GATE_SELECT_CHAR
        |=> s_reg.state == sgad_pkg::SGAD_GATE)
        else $error("gate selector not decoded");

    sel_az_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        s_reg.state == sgad_pkg::SGAD_IDLE && take
        && f_data != sgad_pkg::GATE_SELECT_CHAR
        |=> s_reg.state == sgad_pkg::SGAD_AZ)
        else $error("azimuth selector not decoded");

    gate_len_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        s_reg.state == sgad_pkg::SGAD_GATE && take
        && s_reg.count == sgad_pkg::GATE_BYTES - 4'h1
        |=> s_reg.state == sgad_pkg::SGAD_ACK)
        else $error("gate download not ended at byte twelve");

    addr_high_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        chip_wr_valid_out
        |-> chip_wr_out.addr_hi == sgad_pkg::GATE_SELECT_CHAR)
        else $error("chip write high address not 20");

    data_reg_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        chip_wr_valid_out && !chip_wr_out.is_cmd
        |-> chip_wr_out.addr_lo == s_reg.addr_lo - 8'h01)
        else $error("data write not at command address minus one");

    cmd_reg_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        chip_wr_valid_out && chip_wr_out.is_cmd
        |-> chip_wr_out.addr_lo == s_reg.addr_lo)
        else $error("command write not at command address");

    wr_data_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        s_reg.state == sgad_pkg::SGAD_GATE && take
        && s_reg.count >= sgad_pkg::POS_ADDR_LO
        |=> chip_wr_valid_out && chip_wr_out.data == $past(f_data))
        else $error("chip write data out of order");

    wr_hold_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        chip_wr_valid_out && !chip_wr_ready_in
        |=> chip_wr_valid_out && $stable(chip_wr_out))
        else $error("chip write dropped or changed while stalled");

    slew_set_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        s_reg.state == sgad_pkg::SGAD_AZ && take
        && s_reg.count == sgad_pkg::AZ_CHARS - 4'h1
        |=> slew_request_flag_out == sgad_pkg::SLEW_TO_HOST_AZ)
        else $error("slew flag not set to two");

    az_store_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        s_reg.state == sgad_pkg::SGAD_AZ && take
        && s_reg.count == sgad_pkg::AZ_CHARS - 4'h1
        |=> host_azimuth_store_out == {$past(s_reg.az_buf[11:0]),
                                       $past(f_data[3:0])})
        else $error("azimuth store wrong");

    ack_wait_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        s_reg.state == sgad_pkg::SGAD_ACK && !chip_wr_valid_out
        |-> tx_valid_out && tx_data_out == sgad_pkg::ACK_CHAR)
        else $error("acknowledge missing after last write");

    ack_once_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        tx_valid_out && tx_ready_in
        |=> !tx_valid_out && s_reg.state == sgad_pkg::SGAD_IDLE)
        else $error("acknowledge repeated");

    no_redec_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        s_reg.state == sgad_pkg::SGAD_GATE && take
        |=> s_reg.state == sgad_pkg::SGAD_GATE
            || s_reg.state == sgad_pkg::SGAD_ACK)
        else $error("payload decoded as selector");
endmodule

// File: verification/sgad_host_model.sv
// host computer model on the character link
// assumes the bench calls send_seq and sets slow
`timescale 1ns/1ps
module sgad_host_model (
    // clock
    input  wire logic       clk_in,
    // characters to the device
    output logic            rx_valid_out,
    input  wire logic       rx_ready_in,
    output logic [7:0]      rx_data_out,
    // acknowledge from the device
    input  wire logic       tx_valid_in,
    output logic            tx_ready_out,
    input  wire logic [7:0] tx_data_in
);
    logic       slow;
    int         n_ack;
    logic [7:0] last_ack;

    initial begin
        rx_valid_out = 1'b0;
        rx_data_out  = 8'h00;
        tx_ready_out = 1'b0;
        slow         = 1'b0;
        n_ack        = 0;
        last_ack     = 8'h00;
    end

    // ==========================================================
    // acknowledge side, prompt or stalling
    always @(negedge clk_in) begin
        if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1) begin
            n_ack    <= n_ack + 1;
            last_ack <= tx_data_in;
        end
    end
    always @(posedge clk_in) begin
        tx_ready_out <= slow ? 1'($urandom % 3 == 0) : 1'b1;
    end

    // ==========================================================
    // host byte order
    task automatic send_seq(input logic [7:0] q[$], output bit ok);
        int w;
        ok = 1'b1;
        @(posedge clk_in);
        foreach (q[i]) begin
            rx_valid_out <= 1'b1;
            rx_data_out  <= q[i];
            for (w = 0; w < 2000; w++) begin
                @(negedge clk_in);
                if (rx_ready_in === 1'b1) break;
            end
            if (w == 2000) ok = 1'b0;
            @(posedge clk_in);
        end
        rx_valid_out <= 1'b0;
        rx_data_out  <= ~rx_data_out;
    endtask
endmodule

// File: verification/sgad_top_tb_top.sv
// self-checking bench for the serial gate and azimuth downloader
// assumes the package, design and host model are compiled first
`timescale 1ns/1ps
module sgad_top_tb_top;
    logic                    clk_in, rst_b_in, chip_rdy, stall, clr;
    logic                    rx_valid, rx_ready, tx_valid, tx_ready;
    logic                    chip_valid, busy;
    logic [7:0]              rx_data, tx_data;
    logic [15:0]             az_store, model_az;
    logic [1:0]              flag, model_flag;
    sgad_pkg::sgad_chip_wr_t chip_wr;
    sgad_pkg::sgad_chip_wr_t exp_wr[$];
    int                      n_mismatch, comparisons, t;

    sgad_top i_sgad_top (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .rx_valid_in(rx_valid), .rx_ready_out(rx_ready),
        .rx_data_in(rx_data), .tx_valid_out(tx_valid),
        .tx_ready_in(tx_ready), .tx_data_out(tx_data),
        .chip_wr_valid_out(chip_valid), .chip_wr_ready_in(chip_rdy),
        .chip_wr_out(chip_wr), .host_azimuth_store_out(az_store),
        .slew_request_flag_out(flag), .slew_flag_clear_in(clr),
        .busy_out(busy));
    sgad_host_model i_sgad_host_model (.clk_in(clk_in),
        .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
        .rx_data_out(rx_data), .tx_valid_in(tx_valid),
        .tx_ready_out(tx_ready), .tx_data_in(tx_data));

    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) chip_rdy <= !stall && ($urandom % 4 != 0);

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check_val(input logic [15:0] got, exp, input string s);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s %h not %h", $time, s, got, exp);
        end
    endtask

    task automatic check_wr(input sgad_pkg::sgad_chip_wr_t got, exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: write %h not %h", $time, got, exp);
        end
    endtask

    // ==========================================================
    // chip writes leave in arrival order with their targets
    always @(negedge clk_in) begin
        if (rst_b_in === 1'b1 && chip_valid === 1'b1
            && chip_rdy === 1'b1) begin
            if (exp_wr.size() == 0) begin
                n_mismatch++;
                $display("unexpected at %0t: extra chip write", $time);
            end else begin
                check_wr(chip_wr, exp_wr.pop_front());
            end
        end
    end

    // ==========================================================
    // one download through the host model
    task automatic download(input bit gate, input bit slow, input int n);
        logic [7:0]              q[$];
        logic [7:0]              lo, b;
        sgad_pkg::sgad_chip_wr_t e;
        bit                      ok;
        int                      k, w, acks;
        acks = i_sgad_host_model.n_ack;
        i_sgad_host_model.slow = slow;
        if (gate) begin
            lo = 8'($urandom) | 8'h01;
            q = {sgad_pkg::GATE_SELECT_CHAR, lo};
            for (k = 3; k <= 12; k++) begin
                b = (k == 3) ? 8'h20 : 8'($urandom);
                q.push_back(b);
                e.is_cmd  = (k < 5 || k > 10);
                e.addr_hi = 8'h20;
                e.addr_lo = e.is_cmd ? lo : lo - 8'h01;
                e.data    = b;
                exp_wr.push_back(e);
            end
        end else begin
            b = 8'($urandom);
            q = {(b == 8'h20) ? 8'h21 : b};
            for (k = 0; k < 4; k++) begin
                b = 8'h30 + 8'($urandom % 10);
                q.push_back(b);
                model_az = {model_az[11:0], b[3:0]};
            end
            model_flag = 2'h2;
        end
        fork
            i_sgad_host_model.send_seq(q, ok);
            if (gate && stall) begin
                repeat (40) @(posedge clk_in);
                @(negedge clk_in);
                check_val({15'h0, rx_ready}, 16'h0, "full fifo");
                check_val({15'h0, busy}, 16'h1, "busy mid");
                stall = 1'b0;
            end
        join
        for (w = 0; w < 3000 && i_sgad_host_model.n_ack == acks; w++)
            @(posedge clk_in);
        if (!ok || w == 3000) begin
            n_mismatch++;
            $display("unexpected at %0t: download %0d timed out", $time, n);
            conclude();
        end
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        check_val(16'(i_sgad_host_model.n_ack - acks), 16'h1, "acks");
        check_val({8'h0, i_sgad_host_model.last_ack},
                  {8'h0, sgad_pkg::ACK_CHAR}, "ack char");
        check_val(16'(exp_wr.size()), 16'h0, "writes left");
        check_val(az_store, model_az, "azimuth");
        check_val({14'h0, flag}, {14'h0, model_flag}, "flag");
        check_val({15'h0, busy}, 16'h0, "busy");
        $display("test %0d done", n);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        clk_in      = 1'b0;
        rst_b_in    = 1'b0;
        stall       = 1'b0;
        clr         = 1'b0;
        chip_rdy    = 1'b0;
        n_mismatch  = 0;
        comparisons = 0;
        model_az    = 16'h0000;
        model_flag  = 2'h0;
        void'($urandom(43107));
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(negedge clk_in);
        check_val({15'h0, rx_ready}, 16'h1, "ready");
        check_val({14'h0, flag}, 16'h0, "reset flag");
        download(1'b1, 1'b0, 1);
        download(1'b0, 1'b1, 2);
        @(posedge clk_in);
        clr <= 1'b1;
        @(posedge clk_in);
        clr <= 1'b0;
        model_flag = 2'h0;
        @(negedge clk_in);
        check_val({14'h0, flag}, 16'h0, "flag clear");
        stall = 1'b1;
        download(1'b1, 1'b1, 3);
        for (t = 4; t < 14; t++) download(1'($urandom), 1'($urandom), t);
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rst_b_in <= 1'b1;
        model_az   = 16'h0000;
        model_flag = 2'h0;
        @(negedge clk_in);
        check_val(az_store, model_az, "azimuth after reset");
        check_val({14'h0, flag}, 16'h0, "flag after reset");
        check_val({15'h0, busy}, 16'h0, "busy after reset");
        download(1'b0, 1'b0, 14);
        conclude();
    end

    initial begin
        repeat (60000) @(posedge clk_in);
        n_mismatch++;
        $display("unexpected at %0t: run limit reached", $time);
        conclude();
    end
endmodule
